// *** design/eprom_prog_consts.svh ***
`ifndef EPROM_PROG_CONSTS_SVH
`define EPROM_PROG_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define T_PW_NS 100000
`define T_OPW_UNIT_NS 400000
`define T_LONG_NS 4000000
`define T_SETUP_NS 2000
`define PW_TOL_PCT 5
`define MAX_TRIES 10
`define WORD_W 16
`define ADDR_W 16
`define PW_CYCLES ((`T_PW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPW_UNIT_CYCLES ((`T_OPW_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_CYCLES ((`T_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYCLES ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** design/eprom_prog_pkg.sv ***
`default_nettype none
`include "eprom_prog_consts.svh"
package eprom_prog_pkg;
	typedef logic [`ADDR_W-1:0] word_addr_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_FETCH, ST_SETUP, ST_PULSE, ST_RECOVER, ST_VERIFY, ST_NEXT, ST_READ, ST_DONE, ST_FAIL
	} state_t;
	typedef enum logic [1:0] {PH_INIT, PH_OVER, PH_LONG} phase_t;
endpackage : eprom_prog_pkg
`default_nettype wire

// *** design/eprom_prog_if.sv ***
`default_nettype none
interface tmr_if #(parameter int W = 24);
	logic start;
	logic [W-1:0] load;
	logic done;
	modport ctl(output start, output load, input done);
	modport tmr(input start, input load, output done);
endinterface : tmr_if

interface pad_if;
	logic drive;
	eprom_prog_pkg::word_t wr_word;
	eprom_prog_pkg::word_t rd_word;
	modport ctl(output drive, output wr_word, input rd_word);
	modport pad(input drive, input wr_word, output rd_word);
endinterface : pad_if
`default_nettype wire

// *** design/pulse_timer.sv ***
`default_nettype none
module pulse_timer #(
	parameter int W = 24
) (
	input wire logic mclk,
	input wire logic sys_rst,
	tmr_if.tmr t
);
	logic [W-1:0] cnt_q;
	logic busy_q;
	logic done_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (t.start) begin
			cnt_q <= t.load - W'(1);
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (cnt_q == '0) begin
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		done_q <= !sys_rst && !t.start && busy_q && (cnt_q == '0);
	end

	assign t.done = done_q;
endmodule : pulse_timer
`default_nettype wire

// *** design/data_pad.sv ***
`default_nettype none
`include "eprom_prog_consts.svh"
module data_pad (
	input wire logic mclk,
	input wire logic sys_rst,
	pad_if.pad p,
	input wire eprom_prog_pkg::word_t data_in,
	output var eprom_prog_pkg::word_t data_out,
	output var eprom_prog_pkg::word_t data_oe
);
	import eprom_prog_pkg::*;
	word_t rd_q;

	// Pins registered here so the top sees flip-flop outputs
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			data_out <= '0;
			data_oe <= '0;
			rd_q <= '0;
		end else begin
			data_out <= p.wr_word;
			data_oe <= {`WORD_W{p.drive}};
			rd_q <= data_in;
		end
	end

	assign p.rd_word = rd_q;
endmodule : data_pad
`default_nettype wire

// *** design/eprom_programmer.sv ***
// Overview of operation
// R1: Memory holds 65536 words of 16 bits on parallel lines.
// R2: Select and output drive low, write pulse high: device drives word.
// R3: Select low, output drive high: device data lines float.
// R4: Select high: device in standby, lines float.
// R5: Select low, drive high, write pulse low: device accepts driven word.
// R6: Verify with select and drive low, write pulse high; compare word.
// R7: Erased bits read one; programming only clears bits.
// R8: Start at address zero with valid data before any pulse.
// R9: Initial program pulse lasts 0.1 ms within five percent.
// R10: Read back and decide after every initial pulse.
// R11: Repeat pulse and verify, at most ten pulses per location.
// R12: On pass, one overprogram pulse of 0.4 ms times tries.
// R13: After ten failed tries, one 4 ms pulse then verify.
// R14: Still failing after long pulse: stop and report failure.
// R15: On pass, advance address and repeat until all programmed.
// R16: Address, data, output drive shared; select per device.
// R17: Target device gets its pulse on its own select.
// R18: Devices with select high stay unprogrammed.
// R19: Write pulse stays high outside program pulses.
`default_nettype none
`include "eprom_prog_consts.svh"
module eprom_programmer #(
	parameter int NDEV = 4,
	parameter int DEV_W = 2,
	parameter int TMR_W = 24,
	parameter int PW_CYC = `PW_CYCLES,
	parameter int OPW_CYC = `OPW_UNIT_CYCLES,
	parameter int LONG_CYC = `LONG_CYCLES,
	parameter int SU_CYC = `SETUP_CYCLES,
	parameter int MAX_TRIES = `MAX_TRIES
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [DEV_W-1:0] dev_sel,
	input wire eprom_prog_pkg::word_addr_t last_addr,
	input wire logic word_valid,
	input wire eprom_prog_pkg::word_t word_data,
	input wire logic rd_req,
	input wire eprom_prog_pkg::word_addr_t rd_addr,
	input wire eprom_prog_pkg::word_t data_in,
	output var eprom_prog_pkg::word_t data_out,
	output var eprom_prog_pkg::word_t data_oe,
	output logic [`ADDR_W-1:0] word_address,
	output logic [NDEV-1:0] chip_sel_n,
	output logic output_drive_n,
	output logic write_pulse_n,
	output logic word_req,
	output logic busy,
	output logic prog_done,
	output logic prog_fail,
	output logic rd_valid,
	output logic [`WORD_W-1:0] rd_data
);
	import eprom_prog_pkg::*;

	// ******************************
	// State
	// ******************************
	state_t state_q, state_d;
	phase_t phase_q, phase_d;
	logic [3:0] tries_q, tries_d;
	word_addr_t addr_q, addr_d, last_q, last_d;
	word_t word_q, word_d;
	logic [DEV_W-1:0] sel_q, sel_d;
	logic tstart_q, tstart_d;
	logic [TMR_W-1:0] tload_q, tload_d;
	logic pass;

	tmr_if #(.W(TMR_W)) tif ();
	pad_if pif ();

	pulse_timer #(.W(TMR_W)) u_timer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.t(tif.tmr)
	);

	data_pad u_pad (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.p(pif.pad),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe(data_oe)
	);

	assign tif.start = tstart_q;
	assign tif.load = tload_q;
	// R7: only cleared bits; compare
	assign pass = (pif.rd_word == word_q);
	// R8: data on lines through setup, pulse and hold
	assign pif.drive = (state_d == ST_SETUP) || (state_d == ST_PULSE) || (state_d == ST_RECOVER);
	assign pif.wr_word = word_d;

	// ******************************
	// Sequencer
	// ******************************
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		tries_d = tries_q;
		addr_d = addr_q;
		last_d = last_q;
		word_d = word_q;
		sel_d = sel_q;
		tstart_d = 1'b0;
		tload_d = TMR_W'(SU_CYC);
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					// R8: begin at first location
					state_d = ST_FETCH;
					addr_d = '0;
					last_d = last_addr;
					sel_d = dev_sel;
					phase_d = PH_INIT;
					tries_d = '0;
				end else if (rd_req) begin
					state_d = ST_READ;
					addr_d = rd_addr;
					sel_d = dev_sel;
					tstart_d = 1'b1;
				end
			end
			ST_FETCH: begin
				if (word_valid) begin
					state_d = ST_SETUP;
					word_d = word_data;
					tstart_d = 1'b1;
				end
			end
			ST_SETUP: begin
				if (tif.done) begin
					state_d = ST_PULSE;
					tstart_d = 1'b1;
					if (phase_q == PH_INIT) begin
						// R9: initial pulse width
						tload_d = TMR_W'(PW_CYC);
						tries_d = tries_q + 4'h1;
					end else if (phase_q == PH_OVER) begin
						// R12: overprogram scaled by tries
						tload_d = TMR_W'(OPW_CYC * int'(tries_q));
					end else begin
						// R13: extra long pulse
						tload_d = TMR_W'(LONG_CYC);
					end
				end
			end
			ST_PULSE: begin
				if (tif.done) begin
					if (phase_q == PH_OVER) begin
						state_d = ST_NEXT;
					end else begin
						// R10: read back after every pulse except the overprogram pulse
						state_d = ST_RECOVER;
						tstart_d = 1'b1;
					end
				end
			end
			ST_RECOVER: begin
				if (tif.done) begin
					state_d = ST_VERIFY;
					tstart_d = 1'b1;
				end
			end
			ST_VERIFY: begin
				if (tif.done) begin
					tstart_d = 1'b1;
					if (pass && (phase_q == PH_INIT)) begin
						state_d = ST_SETUP;
						phase_d = PH_OVER;
					end else if (pass) begin
						state_d = ST_NEXT;
						tstart_d = 1'b0;
					end else if ((phase_q == PH_INIT) && (tries_q < 4'(MAX_TRIES))) begin
						// R11: retry up to ten pulses
						state_d = ST_SETUP;
					end else if (phase_q == PH_INIT) begin
						// R13: ten tries failed
						state_d = ST_SETUP;
						phase_d = PH_LONG;
					end else begin
						// R14: stop on final failure
						state_d = ST_FAIL;
						tstart_d = 1'b0;
					end
				end
			end
			ST_NEXT: begin
				// R15: advance until last address
				if (addr_q == last_q) begin
					state_d = ST_DONE;
				end else begin
					state_d = ST_FETCH;
					addr_d = addr_q + 16'h0001;
					phase_d = PH_INIT;
					tries_d = '0;
				end
			end
			ST_READ: begin
				if (tif.done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			phase_q <= PH_INIT;
			tries_q <= '0;
			addr_q <= '0;
			last_q <= '0;
			word_q <= '0;
			sel_q <= '0;
			tstart_q <= 1'b0;
			tload_q <= '0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			tries_q <= tries_d;
			addr_q <= addr_d;
			last_q <= last_d;
			word_q <= word_d;
			sel_q <= sel_d;
			tstart_q <= tstart_d;
			tload_q <= tload_d;
		end
	end

	// ******************************
	// Device pins
	// ******************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			chip_sel_n <= '1;
			output_drive_n <= 1'b1;
			write_pulse_n <= 1'b1;
			word_address <= '0;
		end else begin
			// R17: pulse on target select only; R18: others high
			chip_sel_n <= '1;
			if ((state_d == ST_PULSE) || (state_d == ST_VERIFY) || (state_d == ST_READ)) begin
				chip_sel_n[sel_d] <= 1'b0;
			end
			// R5: drive high during pulse; R3: device floats
			// R6: verify read enable
			output_drive_n <= !((state_d == ST_VERIFY) || (state_d == ST_READ));
			// R19: write pulse high outside pulses
			write_pulse_n <= (state_d != ST_PULSE);
			// R16: shared address lines
			word_address <= addr_d;
		end
	end

	// ******************************
	// User side
	// ******************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			word_req <= 1'b0;
			busy <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			word_req <= (state_d == ST_FETCH);
			busy <= (state_d != ST_IDLE);
			rd_valid <= (state_q == ST_READ) && tif.done;
			if ((state_q == ST_READ) && tif.done) begin
				rd_data <= pif.rd_word;
			end
		end
	end

	// Set wins over the restart clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prog_done <= 1'b0;
			prog_fail <= 1'b0;
		end else begin
			if (state_d == ST_DONE) begin
				prog_done <= 1'b1;
			end else if (start && (state_q == ST_IDLE)) begin
				prog_done <= 1'b0;
			end
			if (state_d == ST_FAIL) begin
				prog_fail <= 1'b1;
			end else if (start && (state_q == ST_IDLE)) begin
				prog_fail <= 1'b0;
			end
		end
	end

	// ******************************
	// Checks
	// ******************************
	logic [TMR_W-1:0] lowlen_q;
	always_ff @(posedge mclk) begin
		if (sys_rst || write_pulse_n) begin
			lowlen_q <= '0;
		end else begin
			lowlen_q <= lowlen_q + TMR_W'(1);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_PULSE_TARGET: assert property (!write_pulse_n |-> output_drive_n && (chip_sel_n == ~(NDEV'(1) << sel_q))) // R17
		else $error("pulse not on target select alone");
	AST_PGM_HIGH: assert property ((state_q != ST_PULSE) |-> write_pulse_n) // R19
		else $error("write pulse low outside pulse");
	AST_PW_LEN: assert property ($rose(write_pulse_n) && (phase_q == PH_INIT)
		|-> (int'(lowlen_q) * 100 >= PW_CYC * (100 - `PW_TOL_PCT))
		&& (int'(lowlen_q) * 100 <= PW_CYC * (100 + `PW_TOL_PCT))) // R9
		else $error("initial pulse width out of tolerance");
	AST_OVER_LEN: assert property ($rose(write_pulse_n) && (phase_q == PH_OVER)
		|-> int'(lowlen_q) == OPW_CYC * int'(tries_q) + 2) // R12
		else $error("overprogram width wrong");
	AST_LONG_LEN: assert property ($rose(write_pulse_n) && (phase_q == PH_LONG)
		|-> int'(lowlen_q) == LONG_CYC + 2) // R13
		else $error("long pulse width wrong");
	AST_VERIFY_AFTER: assert property ($rose(write_pulse_n) && (phase_q != PH_OVER)
		|-> write_pulse_n [*2] ##[1:400] !output_drive_n) // R10
		else $error("no verify after pulse");
	AST_TRIES_MAX: assert property (tries_q <= 4'(MAX_TRIES)) // R11
		else $error("too many tries");
	AST_LONG_ENTRY: assert property ((phase_q == PH_LONG) && ($past(phase_q) == PH_INIT)
		|-> tries_q == 4'(MAX_TRIES)) // R13
		else $error("long pulse before ten tries");
	AST_FAIL_CAUSE: assert property ($rose(prog_fail) |-> (phase_q == PH_LONG) && (state_q == ST_FAIL)) // R14
		else $error("failure without long pulse");
	AST_DATA_VALID: assert property (!write_pulse_n |-> (data_oe == '1) && (data_out == word_q)) // R8
		else $error("data not driven during pulse");
	AST_START_ZERO: assert property ($rose(busy) && (state_q == ST_FETCH) |-> word_address == '0) // R8
		else $error("programming not started at zero");
	AST_ADDR_STEP: assert property (($past(state_q) == ST_NEXT) && (state_q == ST_FETCH)
		|-> word_address == $past(word_address) + 16'h0001) // R15
		else $error("address did not step by one");
	AST_VERIFY_PINS: assert property (!output_drive_n |-> write_pulse_n && (data_oe == '0)
		&& ($countones(~chip_sel_n) == 1)) // R6
		else $error("verify pins wrong");

	COV_DONE: cover property ($rose(prog_done));
	COV_FAIL: cover property ($rose(prog_fail));
	COV_LONG: cover property ($rose(write_pulse_n) && (phase_q == PH_LONG));
	COV_READ: cover property (rd_valid);
endmodule : eprom_programmer
`default_nettype wire

// *** dv/eprom_dev_model.sv ***
`default_nettype none
module eprom_dev_model (
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire eprom_prog_pkg::word_addr_t addr,
	input wire eprom_prog_pkg::word_t dq_in,
	input wire logic [7:0] need,
	output var eprom_prog_pkg::word_t dq_out,
	output var logic dq_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	import eprom_prog_pkg::*;
	// Sparse store: only written words take memory
	word_t mem [word_addr_t];
	int cnt [word_addr_t];
	function automatic word_t rd_word(input word_addr_t a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction : rd_word
	always_comb dq_drv = !cs_n && !oe_n && we_n;
	always @(addr or dq_drv) begin
		dq_out = rd_word(addr);
	end
	// take word on own pulse, clear bits only
	always @(negedge we_n) begin
		#1;
		if (!cs_n && oe_n && !we_n) begin
			cnt[addr] = cnt.exists(addr) ? cnt[addr] + 1 : 1;
			// Stubborn cells: bits settle only after need pulses
			if (cnt[addr] >= int'(need)) mem[addr] = rd_word(addr) & dq_in;
		end
	end
endmodule : eprom_dev_model
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import eprom_prog_pkg::*;
	localparam int PW = 50;
	localparam int OPW = 200;
	localparam int LNG = 500;
	logic mclk, sys_rst, start, word_valid, rd_req, vseen;
	logic output_drive_n, write_pulse_n, word_req, busy, prog_done, prog_fail, rd_valid, d0_drv, d1_drv;
	logic [1:0] dev_sel;
	word_addr_t last_addr, rd_addr, word_address;
	word_t word_data, data_in, data_out, data_oe, rd_data, flt, d0_out, d1_out, cur_w;
	logic [3:0] chip_sel_n, exp_cs;
	logic [7:0] need0, need1;
	int err_count, checks_done, cyc, plen;
	int p_w[$], e_w[$];
	word_addr_t p_a[$], e_a[$];
	bit p_v[$], e_v[$];
	eprom_programmer #(.PW_CYC(PW), .OPW_CYC(OPW), .LONG_CYC(LNG), .SU_CYC(4)) DUT (.mclk(mclk),
		.sys_rst(sys_rst), .start(start), .dev_sel(dev_sel), .last_addr(last_addr),
		.word_valid(word_valid), .word_data(word_data), .rd_req(rd_req), .rd_addr(rd_addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .word_address(word_address),
		.chip_sel_n(chip_sel_n), .output_drive_n(output_drive_n), .write_pulse_n(write_pulse_n),
		.word_req(word_req), .busy(busy), .prog_done(prog_done), .prog_fail(prog_fail),
		.rd_valid(rd_valid), .rd_data(rd_data));
	eprom_dev_model dev0 (.cs_n(chip_sel_n[0]), .oe_n(output_drive_n), .we_n(write_pulse_n),
		.addr(word_address), .dq_in(data_in), .need(need0), .dq_out(d0_out), .dq_drv(d0_drv));
	eprom_dev_model dev1 (.cs_n(chip_sel_n[1]), .oe_n(output_drive_n), .we_n(write_pulse_n),
		.addr(word_address), .dq_in(data_in), .need(need1), .dq_out(d1_out), .dq_drv(d1_drv));
	// ****************
	// Data lines
	// ****************
	// Undriven lines toggle so a stale value never reads as good data
	assign data_in = (data_oe & data_out) | (~data_oe & (d0_drv ? d0_out : (d1_drv ? d1_out : flt)));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		flt <= ~flt;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			test_done();
		end
	end
	// ****************
	// Checking
	// ****************
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("Counts: %0d errors in %0d checks", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	always @(negedge mclk) begin
		if (sys_rst) begin
			plen = 0;
		end else if (write_pulse_n === 1'b0) begin
			if (plen == 0) p_a.push_back(word_address);
			plen++;
			check("pulse pins", {chip_sel_n, output_drive_n, data_oe, data_out}, {exp_cs, 1'b1, 16'hFFFF, cur_w});
		end else begin
			if (plen > 0) begin
				p_w.push_back(plen);
				p_v.push_back(vseen);
				vseen = 0;
			end
			plen = 0;
			if (output_drive_n === 1'b0) vseen = 1;
		end
	end
	task automatic exp_pulse(input int w, input int a, input bit v);
		e_w.push_back(w);
		e_a.push_back(16'(a));
		e_v.push_back(v);
	endtask : exp_pulse
	// ****************
	// Sequences
	// ****************
	task automatic rd(input logic [1:0] dev, input int a, input word_t exp);
		int t;
		@(posedge mclk);
		rd_req <= 1'b1;
		dev_sel <= dev;
		rd_addr <= 16'(a);
		@(posedge mclk);
		rd_req <= 1'b0;
		// Pins stand only until the edge that raises rd_valid
		@(negedge mclk);
		check("read pins", {chip_sel_n, output_drive_n}, {~(4'h1 << dev), 1'b0});
		for (t = 0; rd_valid !== 1'b1 && t < 50; t++) @(negedge mclk);
		check("read word", rd_data, exp);
		for (t = 0; busy !== 1'b0 && t < 50; t++) @(negedge mclk);
	endtask : rd
	task automatic run_prog(input logic [1:0] dev, input int last, input int nd[$], output word_t ew[$]);
		int t, n;
		bit pv;
		word_t w;
		p_w.delete();
		p_a.delete();
		p_v.delete();
		e_w.delete();
		e_a.delete();
		e_v.delete();
		ew.delete();
		pv = 0;
		vseen = 0;
		exp_cs = ~(4'h1 << dev);
		@(posedge mclk);
		start <= 1'b1;
		dev_sel <= dev;
		last_addr <= 16'(last);
		@(posedge mclk);
		start <= 1'b0;
		for (int a = 0; a <= last; a++) begin
			n = nd[a];
			w = 16'($urandom);
			if (a == 0 || w == 16'hFFFF) w = 16'h0000;
			for (t = 0; word_req !== 1'b1 && t < 5000; t++) @(negedge mclk);
			check("word address", word_address, 16'(a));
			repeat (1 + $urandom % 3) @(posedge mclk);
			word_valid <= 1'b1;
			word_data <= w;
			cur_w = w;
			start <= 1'($urandom);
			rd_req <= 1'($urandom);
			if (dev == 2'd0) need0 <= 8'(n);
			else need1 <= 8'(n);
			@(posedge mclk);
			word_valid <= 1'b0;
			start <= 1'b0;
			rd_req <= 1'b0;
			// Let word_req settle low before polling for the next address
			@(negedge mclk);
			for (int k = 0; k < ((n < 10) ? n : 10); k++) begin
				exp_pulse(PW + 2, a, pv);
				pv = 1;
			end
			exp_pulse((n <= 10) ? OPW * n + 2 : LNG + 2, a, 1'b1);
			pv = (n > 10);
			ew.push_back((n <= 11) ? w : 16'hFFFF);
			if (n > 11) break;
		end
		while (ew.size() <= last) ew.push_back(16'hFFFF);
		for (t = 0; busy !== 1'b0 && t < 5000; t++) @(negedge mclk);
		check("end flags", {prog_done, prog_fail}, (nd[nd.size() - 1] > 11) ? 2'b01 : 2'b10);
		check("pulse count", p_w.size(), e_w.size());
		foreach (e_w[i]) if (i < p_w.size()) begin
			check("pulse width", p_w[i], e_w[i]);
			check("pulse address", p_a[i], e_a[i]);
			check("verify before", p_v[i], e_v[i]);
		end
	endtask : run_prog
	initial begin
		int nd[$];
		word_t ew[$];
		mclk = 0;
		sys_rst = 1;
		{start, word_valid, rd_req, dev_sel, vseen} = '0;
		{last_addr, rd_addr, word_data, cur_w, exp_cs} = '0;
		{need0, need1, flt} = {8'h01, 8'h01, 16'h5A5A};
		{err_count, checks_done, cyc, plen} = '0;
		void'($urandom(32'h6FFF));
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		nd = '{1, 10, 11, 1 + $urandom % 10, 1 + $urandom % 10};
		run_prog(2'd0, 4, nd, ew);
		foreach (ew[i]) rd(2'd0, i, ew[i]);
		rd(2'd0, 5, 16'hFFFF);
		rd(2'd1, 2, 16'hFFFF);
		nd = '{1 + $urandom % 10, 12};
		run_prog(2'd1, 1, nd, ew);
		foreach (ew[i]) rd(2'd1, i, ew[i]);
		rd(2'd0, 0, 16'h0000);
		test_done();
	end
endmodule : testbench
`default_nettype wire
